// ===== hw/avivc_map.vh
// constants for the accumulator velocity and indexed variable command block
`ifndef AVIVC_MAP_VH
`define AVIVC_MAP_VH

// instruction numbers
`define AVIVC_OP_ROTATE_LEFT 8'h32
`define AVIVC_OP_ROTATE_RIGHT 8'h33
`define AVIVC_OP_SET_IDX_VAR 8'h37
`define AVIVC_OP_GET_IDX_VAR 8'h38
`define AVIVC_OP_ACC_TO_IDX_VAR 8'h39
`define AVIVC_OP_RESET_APP 8'h83

// addresses and reply fields
`define AVIVC_MODULE_ADDR 8'h01
`define AVIVC_HOST_ADDR 8'h02
`define AVIVC_STATUS_OK 8'h64
`define AVIVC_AXIS_PARAM_TARGET_VEL 8'h02

// frame layout
`define AVIVC_FRAME_LAST 4'h8
`define AVIVC_IDX_ADDR 4'h0
`define AVIVC_IDX_INSTR 4'h1
`define AVIVC_IDX_TYPE 4'h2
`define AVIVC_IDX_BANK 4'h3
`define AVIVC_IDX_CMD 4'h3
`define AVIVC_IDX_VAL3 4'h4
`define AVIVC_IDX_VAL0 4'h7

// motion mode select and direction codes
`define AVIVC_MODE_POSITION 1'b0
`define AVIVC_MODE_VELOCITY 1'b1
`define AVIVC_DIR_LEFT 1'b0
`define AVIVC_DIR_RIGHT 1'b1

// user variable array
`define AVIVC_VAR_DEPTH 256
`define AVIVC_VAR_AW 8

`endif

// ===== hw/avivc_frame_rx.v
// byte collector and checksum checker for nine byte command frames
`timescale 1ns/100ps
`default_nettype none
`include "avivc_map.vh"

module avivc_frame_rx (
  // clock and reset
  input wire clock,
  input wire rst,
  // incoming byte stream
  input wire [7:0] rx_data,
  input wire rx_valid,
  output reg rx_ready_ff,
  // hand back of a consumed frame
  input wire release_frame,
  // decoded frame
  output reg frame_ok_ff,
  output reg [7:0] instr_ff,
  output reg [31:0] value_ff
);

  reg [3:0] cnt_ff;
  reg [7:0] sum_ff;
  reg [7:0] addr_ff;
  wire take;

  assign take = rx_valid & rx_ready_ff;

  // collect bytes in frame order, high value byte first
  always @(posedge clock)
  begin
    if (rst)
    begin
      cnt_ff <= 4'h0;
      sum_ff <= 8'h00;
      addr_ff <= 8'h00;
      instr_ff <= 8'h00;
      value_ff <= 32'h0000_0000;
      rx_ready_ff <= 1'b1;
      frame_ok_ff <= 1'b0;
    end
    else
    begin
      frame_ok_ff <= 1'b0;
      if (release_frame)
        rx_ready_ff <= 1'b1;
      if (take)
      begin
        if (cnt_ff == `AVIVC_FRAME_LAST)
        begin
          cnt_ff <= 4'h0;
          sum_ff <= 8'h00;
          // execute only on good checksum and own address
          if (sum_ff == rx_data && addr_ff == `AVIVC_MODULE_ADDR)
          begin
            frame_ok_ff <= 1'b1;
            rx_ready_ff <= 1'b0;
          end
        end
        else
        begin
          cnt_ff <= cnt_ff + 4'h1;
          sum_ff <= sum_ff + rx_data;
          if (cnt_ff == `AVIVC_IDX_ADDR)
            addr_ff <= rx_data;
          if (cnt_ff == `AVIVC_IDX_INSTR)
            instr_ff <= rx_data;
          if (cnt_ff >= `AVIVC_IDX_VAL3)
            value_ff <= {value_ff[23:0], rx_data};
        end
      end
    end
  end

endmodule // avivc_frame_rx
`default_nettype wire

// ===== hw/avivc_core.v
// command executor for rotate from accumulator and indexed user variables
`timescale 1ns/100ps
`default_nettype none
`include "avivc_map.vh"

module avivc_core (
  // clock and reset
  input wire clock,
  input wire rst,
  // command byte stream in
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  // reply byte stream out
  output reg [7:0] tx_data_ff,
  output reg tx_valid_ff,
  input wire tx_ready,
  // interpreter context
  input wire direct_mode,
  input wire acc_wr_en,
  input wire [31:0] acc_wr_data,
  input wire x_wr_en,
  input wire [31:0] x_wr_data,
  input wire pos_mode_req,
  output reg [31:0] acc_ff,
  output reg [31:0] x_ff,
  // axis interface
  output reg motion_mode_ff,
  output reg rot_dir_ff,
  output reg [31:0] target_vel_ff,
  output reg target_vel_we_ff,
  output reg [7:0] axis_param_ff,
  // program sequencer control
  output reg app_reset_ff
);

  localparam ST_IDLE = 2'd0;
  localparam ST_VEL = 2'd1;
  localparam ST_REPLY = 2'd2;

  reg [1:0] state_ff;
  reg [3:0] idx_ff;
  reg [7:0] csum_ff;
  reg [7:0] cmd_ff;
  reg release_ff;
  reg [31:0] var_mem [0:`AVIVC_VAR_DEPTH-1];
  wire frame_ok;
  wire [7:0] instr;
  wire [31:0] value;
  wire x_in_range;
  wire [`AVIVC_VAR_AW-1:0] var_idx;
  wire [7:0] sum_next;
  wire [3:0] idx_next;
  wire is_rotate;
  wire is_indexed;
  wire known_cmd;

  // frame collection and checksum
  avivc_frame_rx u_frame_rx (
    .clock(clock),
    .rst(rst),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ready_ff(rx_ready),
    .release_frame(release_ff),
    .frame_ok_ff(frame_ok),
    .instr_ff(instr),
    .value_ff(value)
  );

  // decode helpers
  assign x_in_range = (x_ff[31:8] == 24'h00_0000);
  assign var_idx = x_ff[`AVIVC_VAR_AW-1:0];
  assign sum_next = csum_ff + tx_data_ff;
  assign idx_next = idx_ff + 4'h1;
  assign is_rotate = (instr == `AVIVC_OP_ROTATE_LEFT) | (instr == `AVIVC_OP_ROTATE_RIGHT);
  assign is_indexed = (instr == `AVIVC_OP_SET_IDX_VAR) | (instr == `AVIVC_OP_GET_IDX_VAR) |
                      (instr == `AVIVC_OP_ACC_TO_IDX_VAR);
  assign known_cmd = is_rotate | is_indexed | (instr == `AVIVC_OP_RESET_APP);

  // reply byte for a given position; value bytes carry zero
  function [7:0] reply_byte;
    input [3:0] pos;
    input [7:0] cmd;
    input [7:0] sum;
    begin
      case (pos)
        4'h0: reply_byte = `AVIVC_HOST_ADDR;
        4'h1: reply_byte = `AVIVC_MODULE_ADDR;
        4'h2: reply_byte = `AVIVC_STATUS_OK;
        4'h3: reply_byte = cmd;
        4'h8: reply_byte = sum;
        default: reply_byte = 8'h00;
      endcase
    end
  endfunction

  // user variable array writes, only for an index in 0..255
  always @(posedge clock)
  begin
    if (state_ff == ST_IDLE && frame_ok && x_in_range)
    begin
      if (instr == `AVIVC_OP_SET_IDX_VAR)
        var_mem[var_idx] <= value;
      else if (instr == `AVIVC_OP_ACC_TO_IDX_VAR)
        var_mem[var_idx] <= acc_ff;
    end
  end

  // accumulator and x register, command effects win over outside loads
  always @(posedge clock)
  begin
    if (rst)
    begin
      acc_ff <= 32'h0000_0000;
      x_ff <= 32'h0000_0000;
    end
    else if (state_ff == ST_IDLE && frame_ok && instr == `AVIVC_OP_RESET_APP)
    begin
      acc_ff <= 32'h0000_0000;
      x_ff <= 32'h0000_0000;
    end
    else
    begin
      if (state_ff == ST_IDLE && frame_ok && instr == `AVIVC_OP_GET_IDX_VAR && x_in_range)
        acc_ff <= var_mem[var_idx];
      else if (acc_wr_en)
        acc_ff <= acc_wr_data;
      if (x_wr_en)
        x_ff <= x_wr_data;
    end
  end

  // command sequencing, axis updates and reply transmission
  always @(posedge clock)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      idx_ff <= 4'h0;
      csum_ff <= 8'h00;
      cmd_ff <= 8'h00;
      release_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
      motion_mode_ff <= `AVIVC_MODE_POSITION;
      rot_dir_ff <= `AVIVC_DIR_RIGHT;
      target_vel_ff <= 32'h0000_0000;
      target_vel_we_ff <= 1'b0;
      axis_param_ff <= `AVIVC_AXIS_PARAM_TARGET_VEL;
      app_reset_ff <= 1'b0;
    end
    else
    begin
      release_ff <= 1'b0;
      target_vel_we_ff <= 1'b0;
      app_reset_ff <= 1'b0;
      if (pos_mode_req)
        motion_mode_ff <= `AVIVC_MODE_POSITION;
      case (state_ff)
        ST_IDLE:
        begin
          if (frame_ok)
          begin
            cmd_ff <= instr;
            if (is_rotate)
            begin
              // velocity mode is selected first
              motion_mode_ff <= `AVIVC_MODE_VELOCITY;
              if (instr == `AVIVC_OP_ROTATE_LEFT)
                rot_dir_ff <= `AVIVC_DIR_LEFT;
              else
                rot_dir_ff <= `AVIVC_DIR_RIGHT;
              state_ff <= ST_VEL;
            end
            else
            begin
              if (instr == `AVIVC_OP_RESET_APP)
                app_reset_ff <= 1'b1;
              if (known_cmd && direct_mode)
              begin
                tx_data_ff <= `AVIVC_HOST_ADDR;
                tx_valid_ff <= 1'b1;
                idx_ff <= 4'h0;
                csum_ff <= 8'h00;
                state_ff <= ST_REPLY;
              end
              else
                release_ff <= 1'b1;
            end
          end
        end
        ST_VEL:
        begin
          // one cycle after the mode change, speed in pulses per second
          target_vel_ff <= acc_ff;
          target_vel_we_ff <= 1'b1;
          axis_param_ff <= `AVIVC_AXIS_PARAM_TARGET_VEL;
          if (direct_mode)
          begin
            tx_data_ff <= `AVIVC_HOST_ADDR;
            tx_valid_ff <= 1'b1;
            idx_ff <= 4'h0;
            csum_ff <= 8'h00;
            state_ff <= ST_REPLY;
          end
          else
          begin
            release_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_REPLY:
        begin
          if (tx_ready)
          begin
            if (idx_ff == `AVIVC_FRAME_LAST)
            begin
              tx_valid_ff <= 1'b0;
              release_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end
            else
            begin
              // running sum gives the closing checksum byte
              idx_ff <= idx_next;
              csum_ff <= sum_next;
              tx_data_ff <= reply_byte(idx_next, cmd_ff, sum_next);
            end
          end
        end
        default:
        begin
          tx_valid_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // avivc_core
`default_nettype wire

// ===== bench/avivc_sva.sv
// port checker for the command executor
`timescale 1ns/100ps
`default_nettype none
module avivc_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // links
  input wire logic rx_ready,
  input wire logic tx_ready,
  input wire logic tx_valid_ff,
  input wire logic [7:0] tx_data_ff,
  // state and axis
  input wire logic [31:0] acc_ff,
  input wire logic [31:0] x_ff,
  input wire logic motion_mode_ff,
  input wire logic [31:0] target_vel_ff,
  input wire logic target_vel_we_ff,
  input wire logic [7:0] axis_param_ff,
  input wire logic app_reset_ff
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // velocity follows mode select
  mode_first_a: assert property (target_vel_we_ff |-> $past(motion_mode_ff))
    else $error("velocity before mode");
  vel_copy_a: assert property (target_vel_we_ff |-> target_vel_ff == acc_ff && axis_param_ff == 8'h02)
    else $error("bad velocity copy");
  vel_pulse_a: assert property ($rose(motion_mode_ff) |=> target_vel_we_ff ##1 !target_vel_we_ff)
    else $error("velocity write timing");
  reset_clear_a: assert property (app_reset_ff |-> acc_ff == 0 && x_ff == 0 ##1 !app_reset_ff)
    else $error("reset command");
  // reply link
  reply_hold_a: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff))
    else $error("reply dropped");
  reply_busy_a: assert property (tx_valid_ff |-> !rx_ready)
    else $error("input open in reply");
  reply_head_a: assert property ($rose(tx_valid_ff) |-> tx_data_ff == 8'h02)
    else $error("reply head");
  reply_start_a: assert property ($fell(rx_ready) |-> ##[1:4] (tx_valid_ff || rx_ready))
    else $error("no reply start");
  cover property ($rose(target_vel_we_ff));
  cover property (tx_valid_ff && !tx_ready);
  cover property (app_reset_ff);
endmodule // avivc_sva
bind avivc_core avivc_sva chk (.clock, .rst, .rx_ready, .tx_ready, .tx_valid_ff, .tx_data_ff,
  .acc_ff, .x_ff, .motion_mode_ff, .target_vel_ff, .target_vel_we_ff, .axis_param_ff,
  .app_reset_ff);
`default_nettype wire

// ===== bench/avivc_host.sv
// host model sending command frames and taking reply bytes
`timescale 1ns/100ps
`default_nettype none
module avivc_host (
  // clock
  input wire logic clock,
  // command link
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // reply link
  input wire logic [7:0] tx_data_ff,
  input wire logic tx_valid_ff,
  output logic tx_ready
);
  logic slow = 0;
  logic [7:0] rep [0:8];
  int rcnt = 0;
  initial
  begin
    rx_data = 0;
    rx_valid = 0;
    tx_ready = 1;
  end
  // collect reply bytes, stalling every other cycle when slow
  always @(posedge clock)
  begin
    if (tx_valid_ff && tx_ready && rcnt < 9)
    begin
      rep[rcnt] <= tx_data_ff;
      rcnt <= rcnt + 1;
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // send a frame; bad flips bit 0 of the checksum
  task automatic send(input logic [7:0] op, input logic [31:0] v, input bit bad);
    logic [7:0] b [0:8];
    b = '{8'h01, op, 8'h00, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) b[8] += b[i];
    b[8] ^= {7'h00, bad};
    rcnt = 0;
    for (int i = 0; i < 9; i++)
    begin
      rx_data <= b[i];
      rx_valid <= 1'b1;
      @(posedge clock);
      while (rx_ready !== 1'b1) @(posedge clock);
    end
    rx_valid <= 1'b0;
    rx_data <= ~b[8]; // released line shows no stale byte
  endtask
endmodule // avivc_host
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the command executor
`timescale 1ns/100ps
`default_nettype none
`include "avivc_map.vh"
module tb_top;
  logic clock = 0;
  logic rst = 1;
  logic direct_mode = 1;
  logic acc_wr_en = 0;
  logic x_wr_en = 0;
  logic pos_mode_req = 0;
  logic [31:0] acc_wr_data = 0;
  logic [31:0] x_wr_data = 0;
  wire logic [7:0] rx_data, tx_data_ff, axis_param_ff;
  wire logic rx_valid, rx_ready, tx_valid_ff, tx_ready, motion_mode_ff, rot_dir_ff;
  wire logic target_vel_we_ff, app_reset_ff;
  wire logic [31:0] acc_ff, x_ff, target_vel_ff;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int we_cnt = 0;
  int ar_cnt = 0;
  avivc_core dut (.clock, .rst, .rx_data, .rx_valid, .rx_ready, .tx_data_ff, .tx_valid_ff,
    .tx_ready, .direct_mode, .acc_wr_en, .acc_wr_data, .x_wr_en, .x_wr_data, .pos_mode_req,
    .acc_ff, .x_ff, .motion_mode_ff, .rot_dir_ff, .target_vel_ff, .target_vel_we_ff,
    .axis_param_ff, .app_reset_ff);
  avivc_host host (.clock, .rx_data, .rx_valid, .rx_ready, .tx_data_ff, .tx_valid_ff, .tx_ready);
  // clock and hang limit
  always #2 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    // count one-cycle strobes so the rotate and reset scenarios can judge them afterwards
    if (target_vel_we_ff === 1'b1)
      we_cnt <= we_cnt + 1;
    if (app_reset_ff === 1'b1)
      ar_cnt <= ar_cnt + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // load accumulator and index together
  task automatic ld(input logic [31:0] a, input logic [31:0] x);
    acc_wr_data <= a;
    x_wr_data <= x;
    acc_wr_en <= 1;
    x_wr_en <= 1;
    @(posedge clock);
    acc_wr_en <= 0;
    x_wr_en <= 0;
    @(posedge clock);
  endtask
  // send a frame and wait for the input to reopen
  task automatic cmd(input logic [7:0] op, input logic [31:0] v, input bit bad);
    int n;
    host.send(op, v, bad);
    n = 0;
    repeat (2) @(posedge clock);
    while (rx_ready !== 1'b1 && n < 80)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 80) chk("rx_ready", 1, 0);
  endtask
  task automatic chk_reply(input logic [7:0] op);
    logic [7:0] e [0:8];
    e = '{8'h02, 8'h01, 8'h64, op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h67 + op};
    chk("reply count", 9, host.rcnt);
    for (int i = 0; i < 9; i++) chk("reply byte", e[i], host.rep[i]);
  endtask
  // position mode is forced first so the switch to velocity mode is seen
  task automatic t_rotate(input logic [7:0] op, input logic dir, input logic [31:0] v);
    int w;
    pos_mode_req <= 1;
    ld(v, 0);
    pos_mode_req <= 0;
    chk("mode idle", 0, motion_mode_ff);
    w = we_cnt;
    cmd(op, 0, 0);
    chk("rot_dir", dir, rot_dir_ff);
    chk("mode", 1, motion_mode_ff);
    chk("target_vel", v, target_vel_ff);
    chk("vel writes", w + 1, we_cnt);
    chk("axis_param", 32'h0000_0002, axis_param_ff);
    chk_reply(op);
  endtask
  task automatic t_index();
    ld(0, 5);
    cmd(`AVIVC_OP_SET_IDX_VAR, 32'hA5A5_0001, 0);
    chk_reply(`AVIVC_OP_SET_IDX_VAR);
    ld(32'h1234_5678, 6);
    cmd(`AVIVC_OP_ACC_TO_IDX_VAR, 0, 0);
    ld(0, 5);
    cmd(`AVIVC_OP_GET_IDX_VAR, 0, 0);
    chk("var5", 32'hA5A5_0001, acc_ff);
    ld(0, 6);
    cmd(`AVIVC_OP_GET_IDX_VAR, 0, 0);
    chk("var6", 32'h1234_5678, acc_ff);
  endtask
  // out of range index is ignored: no array write, accumulator kept, entry 255 untouched
  task automatic t_range();
    ld(0, 255);
    cmd(`AVIVC_OP_SET_IDX_VAR, 32'h0000_00FF, 0);
    ld(32'h0000_0011, 32'hFFFF_FFFF);
    cmd(`AVIVC_OP_SET_IDX_VAR, 32'h0BAD_0BAD, 0);
    cmd(`AVIVC_OP_ACC_TO_IDX_VAR, 0, 0);
    ld(32'h0000_0077, 256);
    cmd(`AVIVC_OP_GET_IDX_VAR, 0, 0);
    chk("acc kept", 32'h0000_0077, acc_ff);
    ld(0, 255);
    cmd(`AVIVC_OP_GET_IDX_VAR, 0, 0);
    chk("var255", 32'h0000_00FF, acc_ff);
    cmd(`AVIVC_OP_GET_IDX_VAR, 0, 1);
    chk("no reply", 0, host.rcnt);
    ld(32'h0000_0042, 255);
    cmd(`AVIVC_OP_GET_IDX_VAR, 0, 1);
    chk("acc held", 32'h0000_0042, acc_ff);
    cmd(8'h2E, 0, 0);
    chk("unknown quiet", 0, host.rcnt);
    chk("acc unknown", 32'h0000_0042, acc_ff);
  endtask
  // standalone first, then direct mode with its reply
  task automatic t_app_reset();
    int a;
    direct_mode <= 0;
    ld(32'h0000_0055, 9);
    a = ar_cnt;
    cmd(`AVIVC_OP_RESET_APP, 0, 0);
    chk("acc clr", 0, acc_ff);
    chk("x clr", 0, x_ff);
    chk("quiet", 0, host.rcnt);
    chk("app_reset pulse", a + 1, ar_cnt);
    direct_mode <= 1;
    ld(32'h0000_0066, 7);
    cmd(`AVIVC_OP_RESET_APP, 0, 0);
    chk("acc clr direct", 0, acc_ff);
    chk("x clr direct", 0, x_ff);
    chk_reply(`AVIVC_OP_RESET_APP);
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    t_rotate(`AVIVC_OP_ROTATE_LEFT, 0, 32'h0000_1F40);
    host.slow <= 1;
    t_rotate(`AVIVC_OP_ROTATE_RIGHT, 1, 32'h0003_0D40);
    host.slow <= 0;
    t_index();
    t_range();
    t_app_reset();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
